// File: sarec_regs.vh
// register offsets, field positions, reset values for the serial address recognition block
// assumes an 8-bit register address space and an 8-bit data path
`ifndef SAREC_REGS_VH
`define SAREC_REGS_VH

`define SAREC_OFS_SCTL      8'h98
`define SAREC_OFS_RXBUF     8'h99
`define SAREC_OFS_OWN       8'ha9
`define SAREC_OFS_MASK      8'hb9
`define SAREC_OFS_BAUD_LO   8'hc1
`define SAREC_OFS_BAUD_HI   8'hc2
`define SAREC_OFS_ISTAT     8'hc3
`define SAREC_OFS_IMASK     8'hc4

`define SAREC_SCTL_RI       0
`define SAREC_SCTL_TI       1
`define SAREC_SCTL_RB8      2
`define SAREC_SCTL_TB8      3
`define SAREC_SCTL_REN      4
`define SAREC_SCTL_SM2      5
`define SAREC_SCTL_MODE_LO  6
`define SAREC_SCTL_MODE_HI  7

`define SAREC_IST_ACCEPT    0
`define SAREC_IST_MISS      1
`define SAREC_IST_FERR      2

`define SAREC_RST_SCTL      8'h00
`define SAREC_RST_OWN       8'h00
`define SAREC_RST_MASK      8'h00
`define SAREC_RST_BAUD      16'h00ad
`define SAREC_RST_IST       3'h0

`define SAREC_MODE_SHIFT    2'h0
`define SAREC_MODE_8BIT     2'h1

`endif

// File: sarec_top.v
// serial receiver with hardware address recognition and its register file
// assumes a single-cycle register port master on CLK_I and an async RXD line
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "sarec_regs.vh"

module sarec_top (
    input  wire       CLK_I,
    input  wire       RST_N_I,
    input  wire [7:0] ADDR_I,
    input  wire [7:0] WR_DATA_I,
    input  wire       WR_I,
    input  wire       RD_I,
    input  wire       RXD_I,
    output reg  [7:0] RD_DATA_O,
    output reg        IRQ_O
);

    localparam S_IDLE  = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA  = 3'h2;
    localparam S_STOP  = 3'h3;
    localparam S_DONE  = 3'h4;

    // control reset value, split into its fields by the control and receive-result processes
    localparam [7:0] SCTL_RST = `SAREC_RST_SCTL;

    // pattern compare shared by given and broadcast address
    function addr_match;
        input [7:0] addr;
        input [7:0] ref_val;
        input [7:0] care;
        begin
            addr_match = (((addr ^ ref_val) & care) == 8'h00);
        end
    endfunction

    reg  [1:0]  mode;
    reg         multiproc_comm_enable;
    reg         rx_enable;
    reg         tb8;
    reg         rb8;
    reg         ti;
    reg         rx_complete_flag;
    reg  [7:0]  rx_data_buf;
    reg  [7:0]  own_station_address;
    reg  [7:0]  station_address_mask;
    reg  [15:0] baud_div;
    reg  [2:0]  int_status;
    reg  [2:0]  int_mask;

    reg         rxd_s1;
    reg         rxd_s2;
    reg         rxd_q;
    reg  [2:0]  state;
    reg  [15:0] cnt;
    reg  [3:0]  bits;
    reg  [8:0]  shreg;
    reg         stop_bit;

    wire nine_bit = mode[1];
    wire [3:0] nbits = nine_bit ? 4'h9 : 4'h8;

    // mode 0 keeps recognition off whatever the enable bit says
    wire recog_en = multiproc_comm_enable && (mode != `SAREC_MODE_SHIFT);

    wire [7:0] rx_data  = nine_bit ? shreg[7:0] : shreg[8:1];
    wire       rx_ninth = nine_bit ? shreg[8] : stop_bit;
    wire [7:0] bcast    = own_station_address | station_address_mask;
    wire       hit_given = addr_match(rx_data, own_station_address,
                                      station_address_mask);
    wire       hit_bcast = addr_match(rx_data, bcast, bcast);
    wire       hit = hit_given || hit_bcast;

    reg accept;
    always @* begin
        accept = 1'b1;
        if (recog_en) begin
            if (mode == `SAREC_MODE_8BIT) begin
                accept = stop_bit && hit;
            end else begin
                accept = rx_ninth && hit;
            end
        end
    end

    wire done     = (state == S_DONE);
    wire set_ri   = done && accept;
    wire ev_miss  = done && !accept;
    wire ev_ferr  = done && (mode != `SAREC_MODE_SHIFT) && !stop_bit;
    wire [2:0] ev = {ev_ferr, ev_miss, set_ri};

    wire wr_sctl  = WR_I && (ADDR_I == `SAREC_OFS_SCTL);
    wire wr_own   = WR_I && (ADDR_I == `SAREC_OFS_OWN);
    wire wr_mask  = WR_I && (ADDR_I == `SAREC_OFS_MASK);
    wire wr_blo   = WR_I && (ADDR_I == `SAREC_OFS_BAUD_LO);
    wire wr_bhi   = WR_I && (ADDR_I == `SAREC_OFS_BAUD_HI);
    wire wr_ist   = WR_I && (ADDR_I == `SAREC_OFS_ISTAT);
    wire wr_imask = WR_I && (ADDR_I == `SAREC_OFS_IMASK);

    wire [7:0] sctl_view = {mode, multiproc_comm_enable, rx_enable,
                            tb8, rb8, ti, rx_complete_flag};

    // rxd passes two flops before anything looks at it
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_q  <= 1'b1;
        end else begin
            rxd_s1 <= RXD_I;
            rxd_s2 <= rxd_s1;
            rxd_q  <= rxd_s2;
        end
    end

    // receive sequencer: half a bit to centre on the start bit, then whole bits
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state    <= S_IDLE;
            cnt      <= 16'h0000;
            bits     <= 4'h0;
            shreg    <= 9'h000;
            stop_bit <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (rx_enable && rxd_q && !rxd_s2) begin
                        cnt   <= {1'b0, baud_div[15:1]};
                        state <= S_START;
                    end
                end
                S_START: begin
                    if (cnt == 16'h0000) begin
                        // a glitch shorter than half a bit is dropped
                        if (!rxd_s2) begin
                            cnt   <= baud_div;
                            bits  <= 4'h0;
                            state <= S_DATA;
                        end else begin
                            state <= S_IDLE;
                        end
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                S_DATA: begin
                    if (cnt == 16'h0000) begin
                        shreg <= {rxd_s2, shreg[8:1]};
                        bits  <= bits + 4'h1;
                        cnt   <= baud_div;
                        if (bits == nbits - 4'h1) begin
                            if (mode == `SAREC_MODE_SHIFT) begin
                                stop_bit <= 1'b1;
                                state    <= S_DONE;
                            end else begin
                                state <= S_STOP;
                            end
                        end
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                S_STOP: begin
                    if (cnt == 16'h0000) begin
                        stop_bit <= rxd_s2;
                        state    <= S_DONE;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                S_DONE: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // control fields owned by software alone
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode                  <= SCTL_RST[`SAREC_SCTL_MODE_HI:`SAREC_SCTL_MODE_LO];
            multiproc_comm_enable <= SCTL_RST[`SAREC_SCTL_SM2];
            rx_enable             <= SCTL_RST[`SAREC_SCTL_REN];
            tb8                   <= SCTL_RST[`SAREC_SCTL_TB8];
            ti                    <= SCTL_RST[`SAREC_SCTL_TI];
        end else begin
            if (wr_sctl) begin
                mode <= WR_DATA_I[`SAREC_SCTL_MODE_HI:`SAREC_SCTL_MODE_LO];
                multiproc_comm_enable <= WR_DATA_I[`SAREC_SCTL_SM2];
                rx_enable <= WR_DATA_I[`SAREC_SCTL_REN];
                tb8 <= WR_DATA_I[`SAREC_SCTL_TB8];
                ti  <= WR_DATA_I[`SAREC_SCTL_TI];
            end
        end
    end

    // receive results; a frame landing beside a control write wins, so a stale
    // clear from software never hides an accepted frame
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rb8              <= SCTL_RST[`SAREC_SCTL_RB8];
            rx_complete_flag <= SCTL_RST[`SAREC_SCTL_RI];
            rx_data_buf      <= 8'h00;
        end else begin
            if (set_ri) begin
                rb8         <= rx_ninth;
                rx_data_buf <= rx_data;
            end else if (wr_sctl) begin
                rb8 <= WR_DATA_I[`SAREC_SCTL_RB8];
            end
            rx_complete_flag <= (wr_sctl ? WR_DATA_I[`SAREC_SCTL_RI] : rx_complete_flag)
                                | set_ri;
        end
    end

    // address pair; both clear on reset so every address is answered
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            own_station_address  <= `SAREC_RST_OWN;
            station_address_mask <= `SAREC_RST_MASK;
        end else begin
            if (wr_own) begin
                own_station_address <= WR_DATA_I;
            end
            if (wr_mask) begin
                station_address_mask <= WR_DATA_I;
            end
        end
    end

    // divisor bytes are written independently; a half-written value is live
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            baud_div <= `SAREC_RST_BAUD;
        end else begin
            if (wr_blo) begin
                baud_div[7:0] <= WR_DATA_I;
            end
            if (wr_bhi) begin
                baud_div[15:8] <= WR_DATA_I;
            end
        end
    end

    // status is write-one-to-clear; an event in the clearing cycle still sets
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            int_status <= `SAREC_RST_IST;
            int_mask   <= `SAREC_RST_IST;
        end else begin
            int_status <= (int_status & ~(wr_ist ? WR_DATA_I[2:0] : 3'h0)) | ev;
            if (wr_imask) begin
                int_mask <= WR_DATA_I[2:0];
            end
        end
    end

    // read data stand in the cycle after the strobe only
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O <= 8'h00;
            IRQ_O     <= 1'b0;
        end else begin
            IRQ_O <= |(int_status & int_mask);
            if (RD_I) begin
                case (ADDR_I)
                    `SAREC_OFS_SCTL:    RD_DATA_O <= sctl_view;
                    `SAREC_OFS_RXBUF:   RD_DATA_O <= rx_data_buf;
                    `SAREC_OFS_OWN:     RD_DATA_O <= own_station_address;
                    `SAREC_OFS_MASK:    RD_DATA_O <= station_address_mask;
                    `SAREC_OFS_BAUD_LO: RD_DATA_O <= baud_div[7:0];
                    `SAREC_OFS_BAUD_HI: RD_DATA_O <= baud_div[15:8];
                    `SAREC_OFS_ISTAT:   RD_DATA_O <= {5'h00, int_status};
                    `SAREC_OFS_IMASK:   RD_DATA_O <= {5'h00, int_mask};
                    default:            RD_DATA_O <= 8'h00;
                endcase
            end else begin
                RD_DATA_O <= 8'h00;
            end
        end
    end

endmodule
`default_nettype wire

// File: sarec_checker.sv
// checker: register port and interrupt relations seen at sarec_top's pins
// assumes the map of sarec_regs.vh and one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
`include "sarec_regs.vh"
module sarec_checker (
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WR_DATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic       IRQ_O
);
    reg  [7:0] own;
    reg  [7:0] mask;
    reg  [7:3] ctl;
    reg  [2:0] imask;
    wire       mapped = ADDR_I inside {8'h98, 8'h99, 8'ha9, 8'hb9, [8'hc1:8'hc4]};
    // shadows hold only software-owned bits; hardware-set flags stay out
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            own <= 8'h00;
            mask <= 8'h00;
            ctl <= 5'h00;
            imask <= 3'h0;
        end else if (WR_I) begin
            if (ADDR_I == `SAREC_OFS_OWN) own <= WR_DATA_I;
            if (ADDR_I == `SAREC_OFS_MASK) mask <= WR_DATA_I;
            if (ADDR_I == `SAREC_OFS_SCTL) ctl <= WR_DATA_I[7:3];
            if (ADDR_I == `SAREC_OFS_IMASK) imask <= WR_DATA_I[2:0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence wr_mask_s; WR_I && ADDR_I == `SAREC_OFS_MASK; endsequence
    sequence rd_mask_s; RD_I && ADDR_I == `SAREC_OFS_MASK; endsequence
    idle_rd_a: assert property (!RD_I |=> RD_DATA_O == 8'h00)
        else $error("read data not idle");
    unmap_rd_a: assert property (RD_I && !mapped |=> RD_DATA_O == 8'h00)
        else $error("unmapped read not zero");
    own_rd_a: assert property (RD_I && ADDR_I == `SAREC_OFS_OWN |=> RD_DATA_O == own)
        else $error("own address read wrong");
    mask_rd_a: assert property (rd_mask_s |=> RD_DATA_O == mask)
        else $error("mask read wrong");
    mask_echo_a: assert property (wr_mask_s ##1 rd_mask_s |=> RD_DATA_O == $past(WR_DATA_I, 2))
        else $error("mask write not read back");
    ctl_rd_a: assert property (RD_I && ADDR_I == `SAREC_OFS_SCTL |=> RD_DATA_O[7:3] == ctl)
        else $error("control read wrong");
    irq_mask_a: assert property (imask == 3'h0 && $past(imask) == 3'h0 |-> !IRQ_O)
        else $error("irq while all masked");
    stat_rd_a: assert property (RD_I && ADDR_I == `SAREC_OFS_ISTAT |=> RD_DATA_O[7:3] == 5'h00)
        else $error("status spare bits set");
endmodule
bind sarec_top sarec_checker chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
    .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .IRQ_O(IRQ_O));
`default_nettype wire

// File: sarec_station.sv
// master station: drives async frames LSB first onto the receive line
// assumes bit_clks matches the baud divisor the bench programs, plus one
`timescale 1ns/100ps
`default_nettype none
module sarec_station #(
    parameter bit_clks = 5
) (
    input  wire logic clk_i,
    output var  logic rxd_o
);
    integer i;
    initial rxd_o = 1'b1;
    task send(input [8:0] d, input integer n, input stop);
        begin
            rxd_o <= 1'b0;
            repeat (bit_clks) @(posedge clk_i);
            for (i = 0; i < n; i = i + 1) begin
                rxd_o <= d[i];
                repeat (bit_clks) @(posedge clk_i);
            end
            rxd_o <= stop;
            repeat (bit_clks) @(posedge clk_i);
            // back to idle high so a bad stop cannot look like a new start
            rxd_o <= 1'b1;
            repeat (bit_clks) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// File: test_serial_address_recognition.sv
// bench: register port, address filtering per mode, interrupt path
// assumes sarec_station at 5 clocks a bit, baud divisor programmed 4
`timescale 1ns/100ps
`default_nettype none
`include "sarec_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module test_serial_address_recognition;
    logic       clk;
    logic       rst_n;
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
    wire  [7:0] rdata;
    wire        irq;
    wire logic  rxd;
    int         miscompares = 0;
    int         checks_done = 0;
    sarec_top uut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata),
        .WR_I(we), .RD_I(re), .RXD_I(rxd), .RD_DATA_O(rdata), .IRQ_O(irq));
    sarec_station #(.bit_clks(5)) stn (.clk_i(clk), .rxd_o(rxd));
    // the write strobe stays up after a write, so back-to-back writes need no
    // second assignment in one step; whatever follows lowers it
    task wr(input [7:0] a, input [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            we <= 1'b1;
            @(posedge clk);
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        begin
            addr <= a;
            we <= 1'b0;
            re <= 1'b1;
            @(posedge clk);
            re <= 1'b0;
            @(negedge clk);
            `CHK("register read", e, rdata)
            @(posedge clk);
        end
    endtask
    // bit 7 of the control value picks the nine-bit frame length; an accepted
    // frame leaves in bit 2 data bit 8, the stop bit in mode 1, a one in mode 0
    task fr(input [7:0] c, input [8:0] d, input s, input e);
        logic n9;
        begin
            n9 = c[7] ? d[8] : (c[6] ? s : 1'b1);
            wr(`SAREC_OFS_SCTL, c);
            we <= 1'b0;
            stn.send(d, c[7] ? 9 : 8, s);
            repeat (4) @(posedge clk);
            rc(`SAREC_OFS_SCTL, c | {5'h00, e & n9, 1'b0, e});
            if (e) rc(`SAREC_OFS_RXBUF, d[7:0]);
        end
    endtask
    task iq(input e);
        begin
            we <= 1'b0;
            @(posedge clk);
            @(negedge clk);
            `CHK("irq", e, irq)
            @(posedge clk);
        end
    endtask
    task t_reset;
        begin
            rc(`SAREC_OFS_OWN, 8'h00);
            rc(`SAREC_OFS_MASK, 8'h00);
            rc(8'h50, 8'h00);
            wr(`SAREC_OFS_BAUD_LO, 8'h04);
            wr(`SAREC_OFS_BAUD_HI, 8'h00);
            fr(8'hb0, 9'h12c, 1'b1, 1'b1);
            wr(`SAREC_OFS_MASK, 8'ha5);
            rc(`SAREC_OFS_MASK, 8'ha5);
        end
    endtask
    task t_mode2;
        begin
            wr(`SAREC_OFS_OWN, 8'h56);
            wr(`SAREC_OFS_MASK, 8'hfc);
            fr(8'hb0, 9'h157, 1'b1, 1'b1);
            fr(8'hb0, 9'h15a, 1'b1, 1'b0);
            fr(8'hb0, 9'h1fe, 1'b1, 1'b1);
            fr(8'hb0, 9'h057, 1'b1, 1'b0);
            fr(8'h90, 9'h05a, 1'b1, 1'b1);
        end
    endtask
    task t_mode1;
        begin
            wr(`SAREC_OFS_OWN, 8'h33);
            wr(`SAREC_OFS_MASK, 8'hff);
            fr(8'h70, 9'h034, 1'b1, 1'b0);
            fr(8'h70, 9'h033, 1'b0, 1'b0);
            fr(8'h70, 9'h033, 1'b1, 1'b1);
            fr(8'h30, 9'h034, 1'b1, 1'b1);
        end
    endtask
    task t_irq;
        begin
            wr(`SAREC_OFS_ISTAT, 8'h07);
            wr(`SAREC_OFS_IMASK, 8'h01);
            fr(8'hb0, 9'h134, 1'b1, 1'b0);
            iq(1'b0);
            fr(8'hb0, 9'h133, 1'b1, 1'b1);
            iq(1'b1);
            wr(`SAREC_OFS_IMASK, 8'h00);
            iq(1'b0);
            wr(`SAREC_OFS_IMASK, 8'h01);
            iq(1'b1);
            wr(`SAREC_OFS_ISTAT, 8'h01);
            iq(1'b0);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d miscompares %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #500000;
        miscompares++;
        wrap_up;
    end
    initial begin
        rst_n = 1'b0;
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_mode2;
        t_mode1;
        t_irq;
        wrap_up;
    end
endmodule
`default_nettype wire
